// ---- src/cie_core.sv ----
// execute step for watchdog clear, call via working, complement, clears and decrements
`timescale 1ns/1ns
`default_nettype none
module cie_core (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire cie_pkg::cie_op_e instr_op,
    input wire logic [cie_pkg::CIE_FADDR_W-1:0] file_addr,
    input wire logic dest_sel,
    input wire logic [cie_pkg::CIE_LATCH_W-1:0] pc_high_latch,
    input wire logic timeout_evt,
    input wire logic sleep_evt,
    input wire logic load_en,
    input wire logic [cie_pkg::CIE_FADDR_W-1:0] load_addr,
    input wire logic [cie_pkg::CIE_DATA_W-1:0] load_data,
    input wire logic [cie_pkg::CIE_FADDR_W-1:0] peek_addr,
    output logic [cie_pkg::CIE_DATA_W-1:0] peek_data_r,
    output logic [cie_pkg::CIE_DATA_W-1:0] w_r,
    output logic z_r,
    output logic timeout_flag_n_r,
    output logic powerdown_flag_n_r,
    output logic watchdog_clear_r,
    output logic [cie_pkg::CIE_PC_W-1:0] pc_r,
    output logic [cie_pkg::CIE_PC_W-1:0] stack_top_r,
    output logic [cie_pkg::CIE_SP_W-1:0] sp_r,
    output logic busy_r
);
    import cie_pkg::*;

    cie_state_e state_r;
    logic [CIE_DATA_W-1:0] file_mem [CIE_FILE_DEPTH];
    logic [CIE_PC_W-1:0] stack_mem [CIE_STACK_DEPTH];
    logic take;
    logic [CIE_DATA_W-1:0] operand;
    logic [CIE_DATA_W-1:0] result_nxt;
    logic has_result;
    logic to_file;
    logic to_w;
    logic z_upd;
    logic skip_nxt;
    logic [CIE_PC_W-1:0] pc_inc;

    // an instruction is taken only in the execute state; the second cycle refuses it
    assign take = instr_valid && (state_r == ST_EXEC);
    assign operand = file_mem[file_addr];
    assign pc_inc = pc_r + CIE_PC_STEP;

    // result of the file-oriented operations and where it goes
    always_comb begin
        result_nxt = CIE_BYTE_ZERO;
        has_result = 1'b0;
        z_upd = 1'b0;
        unique case (instr_op)
            OP_COMPLEMENT: begin
                result_nxt = ~operand;
                has_result = 1'b1;
                z_upd = 1'b1;
            end
            OP_DECREMENT: begin
                result_nxt = operand - CIE_BYTE_ONE;
                has_result = 1'b1;
                z_upd = 1'b1;
            end
            OP_DEC_SKIP: begin
                result_nxt = operand - CIE_BYTE_ONE;
                has_result = 1'b1;
            end
            OP_CLEAR_FILE: begin
                z_upd = 1'b1;
            end
            OP_CLEAR_WORKING: begin
                z_upd = 1'b1;
            end
            default: begin
                result_nxt = CIE_BYTE_ZERO;
            end
        endcase
    end

    assign to_file = take && ((has_result && dest_sel == CIE_DEST_F) || instr_op == OP_CLEAR_FILE);
    assign to_w = take && ((has_result && dest_sel == CIE_DEST_W) || instr_op == OP_CLEAR_WORKING);
    assign skip_nxt = take && instr_op == OP_DEC_SKIP && result_nxt == CIE_BYTE_ZERO;

    // file storage: the executing instruction wins over a load from outside
    always_ff @(posedge mclk) begin
        if (to_file) begin
            file_mem[file_addr] <= result_nxt;
        end else if (load_en) begin
            file_mem[load_addr] <= load_data;
        end
    end

    // registered peek keeps the output straight from a flop
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            peek_data_r <= CIE_BYTE_ZERO;
        end else begin
            peek_data_r <= file_mem[peek_addr];
        end
    end

    // working register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            w_r <= CIE_W_RST;
        end else if (to_w) begin
            w_r <= result_nxt;
        end
    end

    // zero flag follows the result of complement and decrement; clears force it set
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            z_r <= CIE_Z_RST;
        end else if (take && z_upd) begin
            z_r <= (result_nxt == CIE_BYTE_ZERO);
        end
    end

    // timeout and powerdown flags; a hardware event in the same cycle beats the set
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            timeout_flag_n_r <= CIE_FLAG_N_RST;
            powerdown_flag_n_r <= CIE_FLAG_N_RST;
        end else begin
            if (timeout_evt) begin
                timeout_flag_n_r <= 1'b0;
            end else if (take && instr_op == OP_WATCHDOG_CLR) begin
                timeout_flag_n_r <= 1'b1;
            end
            if (sleep_evt) begin
                powerdown_flag_n_r <= 1'b0;
            end else if (take && instr_op == OP_WATCHDOG_CLR) begin
                powerdown_flag_n_r <= 1'b1;
            end
        end
    end

    // one-cycle clear to the watchdog, zeroing counter and prescaler together
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            watchdog_clear_r <= 1'b0;
        end else begin
            watchdog_clear_r <= take && instr_op == OP_WATCHDOG_CLR;
        end
    end

    // program counter and the second cycle of two-cycle instructions
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pc_r <= CIE_PC_RST;
            state_r <= ST_EXEC;
            busy_r <= 1'b0;
        end else if (state_r == ST_SECOND) begin
            state_r <= ST_EXEC; // the inserted cycle does nothing else
            busy_r <= 1'b0;
        end else if (take) begin
            if (instr_op == OP_CALL_VIA_W) begin
                pc_r <= {pc_high_latch, w_r};
                state_r <= ST_SECOND;
                busy_r <= 1'b1;
            end else if (skip_nxt) begin
                pc_r <= pc_r + CIE_PC_SKIP;
                state_r <= ST_SECOND;
                busy_r <= 1'b1;
            end else begin
                pc_r <= pc_inc;
            end
        end
    end

    // return stack: circular, sixteen levels, overflow wraps silently
    always_ff @(posedge mclk) begin
        if (take && instr_op == OP_CALL_VIA_W) begin
            stack_mem[sp_r] <= pc_inc;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sp_r <= CIE_SP_RST;
            stack_top_r <= CIE_PC_RST;
        end else if (take && instr_op == OP_CALL_VIA_W) begin
            sp_r <= sp_r + CIE_SP_STEP;
            stack_top_r <= pc_inc;
        end
    end

    logic call_take;
    logic wdg_take;
    assign call_take = take && instr_op == OP_CALL_VIA_W;
    // back-to-back clears legally keep the pulse high, so the fall check must allow them
    assign wdg_take = take && instr_op == OP_WATCHDOG_CLR;

    AST_WDG_CLEAR: assert property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_WATCHDOG_CLR && !timeout_evt && !sleep_evt
        |=> watchdog_clear_r && timeout_flag_n_r && powerdown_flag_n_r
        ##1 (!watchdog_clear_r || $past(wdg_take)))
        else $error("watchdog clear did not pulse or set flags");
    AST_CALL_PUSH: assert property (@(posedge mclk) disable iff (!nrst)
        call_take |=> stack_top_r == $past(pc_inc) && sp_r == $past(sp_r) + CIE_SP_STEP
        && stack_mem[$past(sp_r)] == $past(pc_inc))
        else $error("call did not push pc plus one");
    AST_CALL_TARGET: assert property (@(posedge mclk) disable iff (!nrst)
        call_take |=> pc_r == {$past(pc_high_latch), $past(w_r)})
        else $error("call target wrong");
    AST_CALL_TWO: assert property (@(posedge mclk) disable iff (!nrst)
        call_take |=> busy_r && $stable(z_r) ##1 !busy_r && $stable(z_r))
        else $error("call not two cycles or flag changed");
    AST_COMPLEMENT: assert property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_COMPLEMENT && dest_sel == CIE_DEST_W
        |=> w_r == ~$past(operand) && z_r == (w_r == CIE_BYTE_ZERO))
        else $error("complement to working wrong");
    AST_CLEAR_FILE: assert property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_CLEAR_FILE |=> z_r && file_mem[$past(file_addr)] == CIE_BYTE_ZERO)
        else $error("clear file wrong");
    AST_CLEAR_W: assert property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_CLEAR_WORKING |=> z_r && w_r == CIE_BYTE_ZERO)
        else $error("clear working wrong");
    AST_DECREMENT: assert property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_DECREMENT && dest_sel == CIE_DEST_W
        |=> w_r == $past(operand) - CIE_BYTE_ONE && !busy_r)
        else $error("decrement to working wrong");
    AST_DEC_SKIP: assert property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_DEC_SKIP && operand == CIE_BYTE_ONE
        |=> busy_r && $stable(z_r) && pc_r == $past(pc_r) + CIE_PC_SKIP ##1 !busy_r)
        else $error("decrement skip did not insert a nop");
    AST_ZERO_FLAG: assert property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_DECREMENT && dest_sel == CIE_DEST_F
        |=> z_r == (file_mem[$past(file_addr)] == CIE_BYTE_ZERO))
        else $error("zero flag does not match stored result");

    COV_CALL: cover property (@(posedge mclk) disable iff (!nrst) call_take ##2 take);
    COV_SKIP: cover property (@(posedge mclk) disable iff (!nrst) skip_nxt);
    COV_WDG: cover property (@(posedge mclk) disable iff (!nrst) watchdog_clear_r);
    COV_DEC_ZERO: cover property (@(posedge mclk) disable iff (!nrst)
        take && instr_op == OP_DECREMENT && result_nxt == CIE_BYTE_ZERO);
endmodule // cie_core
`default_nettype wire

// ---- src/cie_pkg.sv ----
// constants and types shared by the instruction execute subset
package cie_pkg;
    localparam int unsigned CIE_DATA_W = 8;
    localparam int unsigned CIE_FADDR_W = 7;
    localparam int unsigned CIE_PC_W = 15;
    localparam int unsigned CIE_LATCH_W = 7;
    localparam int unsigned CIE_STACK_DEPTH = 16;
    localparam int unsigned CIE_SP_W = 4;
    localparam int unsigned CIE_FILE_DEPTH = 128;
    // field positions of the call target
    localparam int unsigned CIE_PC_LO_MSB = 7;
    localparam int unsigned CIE_PC_HI_LSB = 8;
    // reset values
    localparam logic [7:0] CIE_W_RST = 8'h00;
    localparam logic [14:0] CIE_PC_RST = 15'h0000;
    localparam logic [3:0] CIE_SP_RST = 4'h0;
    localparam logic CIE_FLAG_N_RST = 1'b1;
    localparam logic CIE_Z_RST = 1'b0;
    // values used by the execute step
    localparam logic [7:0] CIE_BYTE_ZERO = 8'h00;
    localparam logic [7:0] CIE_BYTE_ONE = 8'h01;
    localparam logic [14:0] CIE_PC_STEP = 15'h0001;
    localparam logic [14:0] CIE_PC_SKIP = 15'h0002;
    localparam logic [3:0] CIE_SP_STEP = 4'h1;
    // destination select: 0 to working register, 1 back to the file
    localparam logic CIE_DEST_W = 1'b0;
    localparam logic CIE_DEST_F = 1'b1;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_WATCHDOG_CLR,
        OP_CALL_VIA_W,
        OP_COMPLEMENT,
        OP_CLEAR_FILE,
        OP_CLEAR_WORKING,
        OP_DECREMENT,
        OP_DEC_SKIP
    } cie_op_e;

    typedef enum logic {
        ST_EXEC,
        ST_SECOND
    } cie_state_e;
endpackage

// ---- verification/cie_tb.sv ----
// self-checking bench for the instruction execute subset
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import cie_pkg::*;
    typedef struct packed {
        cie_op_e op;
        logic [6:0] a;
        logic d;
        logic [7:0] i;
        logic [7:0] w;
        logic z;
        logic [7:0] f;
    } cie_row_s;
    // op, address, destination, preload, expected working, zero, file byte
    localparam cie_row_s ROWS [13] = '{
        '{OP_COMPLEMENT, 7'h05, 1'h0, 8'h5A, 8'hA5, 1'h0, 8'h5A},
        '{OP_COMPLEMENT, 7'h7F, 1'h1, 8'hFF, 8'hA5, 1'h1, 8'h00},
        '{OP_DECREMENT, 7'h00, 1'h0, 8'h80, 8'h7F, 1'h0, 8'h80},
        '{OP_CLEAR_FILE, 7'h20, 1'h0, 8'h3C, 8'h7F, 1'h1, 8'h00},
        '{OP_DECREMENT, 7'h10, 1'h1, 8'h00, 8'h7F, 1'h0, 8'hFF},
        '{OP_CLEAR_WORKING, 7'h11, 1'h0, 8'h44, 8'h00, 1'h1, 8'h44},
        '{OP_DECREMENT, 7'h01, 1'h0, 8'h01, 8'h00, 1'h1, 8'h01},
        '{OP_DEC_SKIP, 7'h02, 1'h0, 8'h05, 8'h04, 1'h1, 8'h05},
        '{OP_COMPLEMENT, 7'h04, 1'h0, 8'h00, 8'hFF, 1'h0, 8'h00},
        '{OP_DEC_SKIP, 7'h03, 1'h1, 8'h01, 8'hFF, 1'h0, 8'h00},
        '{OP_NOP, 7'h06, 1'h0, 8'h77, 8'hFF, 1'h0, 8'h77},
        '{OP_DEC_SKIP, 7'h08, 1'h0, 8'h01, 8'h00, 1'h0, 8'h01},
        '{OP_DEC_SKIP, 7'h09, 1'h1, 8'h00, 8'h00, 1'h0, 8'hFF}
    };
    logic mclk = 1'h0, nrst = 1'h0, instr_valid = 1'h0, dest_sel = 1'h0;
    logic timeout_evt = 1'h0, sleep_evt = 1'h0, load_en = 1'h0;
    cie_op_e instr_op = OP_NOP;
    logic [6:0] file_addr = 7'h00, pc_high_latch = 7'h00, load_addr = 7'h00, peek_addr = 7'h00;
    logic [7:0] load_data = 8'h00;
    logic [7:0] peek_data_r, w_r;
    logic z_r, timeout_flag_n_r, powerdown_flag_n_r, watchdog_clear_r, busy_r;
    logic [14:0] pc_r, stack_top_r, exp_pc;
    logic [3:0] sp_r, old_sp;
    logic skip;
    cie_row_s r;
    int n_errors = 0, comparisons = 0, cycles = 0;

    cie_core i_dut (.mclk(mclk), .nrst(nrst), .instr_valid(instr_valid), .instr_op(instr_op),
        .file_addr(file_addr), .dest_sel(dest_sel), .pc_high_latch(pc_high_latch),
        .timeout_evt(timeout_evt), .sleep_evt(sleep_evt), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .peek_addr(peek_addr), .peek_data_r(peek_data_r), .w_r(w_r), .z_r(z_r),
        .timeout_flag_n_r(timeout_flag_n_r), .powerdown_flag_n_r(powerdown_flag_n_r),
        .watchdog_clear_r(watchdog_clear_r), .pc_r(pc_r), .stack_top_r(stack_top_r), .sp_r(sp_r),
        .busy_r(busy_r));

    // 50 MHz clock
    always #10 mclk = ~mclk;

    // hang guard: the whole run needs under a hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic load(input logic [6:0] a, input logic [7:0] v);
        load_en = 1'h1;
        load_addr = a;
        load_data = v;
        tick();
        load_en = 1'h0;
    endtask

    // hold keeps valid up so the next call lands on the very next edge
    task automatic exec(input cie_op_e op, input logic [6:0] a, input logic d, input bit hold);
        instr_valid = 1'h1;
        instr_op = op;
        file_addr = a;
        dest_sel = d;
        tick();
        if (!hold) instr_valid = 1'h0;
    endtask

    // peek is registered, so the byte shows one edge later
    task automatic peek(input logic [6:0] a, input logic [7:0] exp);
        peek_addr = a;
        tick();
        check(15'(peek_data_r), 15'(exp));
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        #1;
        nrst = 1'h1;
        exp_pc = CIE_PC_RST;
        check(15'({timeout_flag_n_r, powerdown_flag_n_r}), 15'h0003);
        for (int k = 0; k < 13; k++) begin
            r = ROWS[k];
            skip = (r.op == OP_DEC_SKIP) && (r.i == 8'h01);
            load(r.a, r.i);
            exec(r.op, r.a, r.d, 1'b0);
            exp_pc = exp_pc + (skip ? 15'h0002 : 15'h0001);
            check(15'(w_r), 15'(r.w));
            check(15'(z_r), 15'(r.z));
            check(15'(busy_r), 15'(skip));
            check(pc_r, exp_pc);
            peek(r.a, r.f);
        end
        // back-to-back decrements of one byte
        load(7'h40, 8'h02);
        exec(OP_DECREMENT, 7'h40, 1'h1, 1'b1);
        exec(OP_DECREMENT, 7'h40, 1'h1, 1'b0);
        exp_pc = exp_pc + 15'h0002;
        check(15'(z_r), 15'h0001);
        check(pc_r, exp_pc);
        peek(7'h40, 8'h00);
        // flags knocked low, then restored by the watchdog clear
        timeout_evt = 1'h1;
        sleep_evt = 1'h1;
        tick();
        timeout_evt = 1'h0;
        sleep_evt = 1'h0;
        check(15'({timeout_flag_n_r, powerdown_flag_n_r}), 15'h0000);
        exec(OP_WATCHDOG_CLR, 7'h00, 1'h0, 1'b0);
        exp_pc = exp_pc + 15'h0001;
        check(15'({timeout_flag_n_r, powerdown_flag_n_r}), 15'h0003);
        check(15'(watchdog_clear_r), 15'h0001);
        tick();
        check(15'(watchdog_clear_r), 15'h0000);
        // call via working, with a clear of working offered while busy
        load(7'h50, 8'h3C);
        exec(OP_COMPLEMENT, 7'h50, 1'h0, 1'b0);
        exp_pc = exp_pc + 15'h0001;
        pc_high_latch = 7'h5A;
        old_sp = sp_r;
        exec(OP_CALL_VIA_W, 7'h00, 1'h0, 1'b1);
        instr_op = OP_CLEAR_WORKING;
        check(stack_top_r, exp_pc + 15'h0001);
        check(15'(sp_r), 15'(old_sp + 4'h1));
        check(pc_r, {7'h5A, 8'hC3});
        check(15'({busy_r, z_r, timeout_flag_n_r}), 15'h0005);
        tick();
        instr_valid = 1'h0;
        check(15'(w_r), 15'h00C3);
        check(pc_r, {7'h5A, 8'hC3});
        check(15'(busy_r), 15'h0000);
        // a timeout in the same cycle as the clear keeps its flag low
        timeout_evt = 1'h1;
        exec(OP_WATCHDOG_CLR, 7'h00, 1'h0, 1'b0);
        timeout_evt = 1'h0;
        check(15'({timeout_flag_n_r, powerdown_flag_n_r}), 15'h0001);
        // mid-run reset, then an instruction at the first edge after release
        nrst = 1'h0;
        tick();
        check(15'({w_r, z_r, busy_r, watchdog_clear_r, peek_data_r}), 15'h0000);
        check(15'({timeout_flag_n_r, powerdown_flag_n_r}), 15'h0003);
        check(pc_r, CIE_PC_RST);
        check(stack_top_r | 15'(sp_r), 15'h0000);
        nrst = 1'h1;
        exec(OP_CLEAR_WORKING, 7'h00, 1'h0, 1'b0);
        check(15'(z_r), 15'h0001);
        check(pc_r, CIE_PC_STEP);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
